// file: testbench.sv
/* testbench: host and device joined by uts_if, run from the host port.
   Assumes the host makes sck itself; device outputs are judged. */
`timescale 1ns/100ps
module testbench;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic pll_locked_in = 1'b0;
   logic tx_burst_in = 1'b0;
   logic [7:0] rdata_out;
   logic [1:0] op_mode_out;
   logic [2:0] amp_atten_out;
   logic amp_en_out, regulator_on_out, xosc_en_out, pll_enable_out, lock_indicator_out;
   int err_count = 0;
   int checked = 0;
   uts_if link ();
   uts_host uts_host_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(link),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out));
   uts_dev uts_dev_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(link),
      .pll_locked_in(pll_locked_in), .tx_burst_in(tx_burst_in),
      .op_mode_out(op_mode_out), .amp_atten_out(amp_atten_out),
      .amp_en_out(amp_en_out), .regulator_on_out(regulator_on_out),
      .xosc_en_out(xosc_en_out), .pll_enable_out(pll_enable_out),
      .lock_indicator_out(lock_indicator_out));
   uts_asserts uts_asserts_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .sck(link.sck), .si(link.si), .en_n(link.en_n), .so_drv(link.so_drv),
      .so_oe(link.so_oe));
   // =====
   // 200 MHz clock
   always #2.5 mclk_in = ~mclk_in;
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task hwr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task hrd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   // one frame; busy is polled under a bound so a stuck host cannot hang us
   task frame(input logic rw, input logic [4:0] a, input logic [7:0] d,
      output logic [7:0] q);
      logic [7:0] s;
      logic [11:0] n;
      hwr(3'h1, d);
      hwr(3'h0, {rw, 2'h0, a});
      n = 12'h000;
      s = 8'h01;
      repeat (4) @(posedge mclk_in);
      while (s[0] !== 1'b0 && n < 12'hBB8)
      begin
         hrd(3'h2, s);
         n++;
      end
      chk("busy", 8'h00, {7'h00, s[0]});
      hrd(3'h3, q);
      repeat (8) @(posedge mclk_in);
   endtask
   // power-up values; the last address lies past the bank
   task t_defaults;
      logic [7:0] q;
      logic [4:0] ad [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h11, 5'h12};
      logic [7:0] ex [8] = '{8'h3F, 8'h7D, 8'h02, 8'h4B, 8'h0C, 8'h1A, 8'hDD, 8'h00};
      for (int i = 0; i < 8; i++)
      begin
         frame(1'b1, ad[i], 8'h00, q);
         chk("reg", ex[i], q);
      end
   endtask
   task t_atten;
      logic [7:0] q;
      for (int i = 0; i < 8; i++)
      begin
         frame(1'b0, 5'h00, {3'h1, 3'(i), 2'h3}, q);
         chk("atten", 8'(i), {5'h00, amp_atten_out});
         chk("mode", 8'h01, {6'h00, op_mode_out});
         chk("amp", 8'h00, {7'h00, amp_en_out});
         chk("ldo", 8'h01, {7'h00, regulator_on_out});
         chk("xosc", 8'h01, {7'h00, xosc_en_out});
      end
   endtask
   task t_tx;
      logic [7:0] q;
      frame(1'b0, 5'h00, 8'h7F, q);
      chk("amp", 8'h01, {7'h00, amp_en_out});
      hwr(3'h0, 8'h80);
      repeat (4) @(posedge mclk_in);
      hrd(3'h2, q);
      chk("refused", 8'h02, q & 8'h02);
      chk("en_n", 8'h01, {7'h00, link.en_n});
   endtask
   // lock-gated amplifier through an open-loop burst
   task t_gated;
      logic [7:0] q;
      frame(1'b0, 5'h01, 8'h7F, q);
      chk("amp", 8'h00, {7'h00, amp_en_out});
      pll_locked_in <= 1'b1;
      repeat (10) @(posedge mclk_in);
      chk("lock", 8'h01, {7'h00, lock_indicator_out});
      chk("amp", 8'h01, {7'h00, amp_en_out});
      hwr(3'h4, 8'h03);
      tx_burst_in <= 1'b1;
      repeat (10) @(posedge mclk_in);
      chk("pll", 8'h00, {7'h00, pll_enable_out});
      hwr(3'h4, 8'h00);
      tx_burst_in <= 1'b0;
      repeat (10) @(posedge mclk_in);
      chk("amp", 8'h00, {7'h00, amp_en_out});
      chk("pll", 8'h01, {7'h00, pll_enable_out});
      chk("txpin", 8'h01, {7'h00, link.tx_line});
      pll_locked_in <= 1'b0;
      repeat (10) @(posedge mclk_in);
      pll_locked_in <= 1'b1;
      repeat (10) @(posedge mclk_in);
      chk("amp", 8'h01, {7'h00, amp_en_out});
   endtask
   task t_power;
      logic [7:0] q;
      frame(1'b0, 5'h01, 8'h7E, q);
      chk("lock", 8'h00, {7'h00, lock_indicator_out});
      frame(1'b0, 5'h01, 8'h75, q);
      chk("ldo", 8'h00, {7'h00, regulator_on_out});
      frame(1'b0, 5'h01, 8'h7D, q);
      frame(1'b0, 5'h00, 8'h5F, q);
      chk("amp", 8'h00, {7'h00, amp_en_out});
      chk("pll", 8'h01, {7'h00, pll_enable_out});
      frame(1'b0, 5'h00, 8'h1F, q);
      chk("ldo", 8'h00, {7'h00, regulator_on_out});
      chk("xosc", 8'h00, {7'h00, xosc_en_out});
      chk("pll", 8'h00, {7'h00, pll_enable_out});
      chk("amp", 8'h00, {7'h00, amp_en_out});
      frame(1'b1, 5'h00, 8'h00, q);
      chk("reg", 8'h1F, q);
   endtask
   task results;
      if (err_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // reset two cycles; every flop with a reset loads its reset value on its first reset edge
   initial
   begin
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      t_defaults;
      t_atten;
      t_tx;
      t_gated;
      t_power;
      results;
   end
   // watchdog, about a fifth past the expected run
   initial
   begin
      #490000;
      err_count++;
      results;
   end
endmodule

// file: uts_asserts.sv
/* uts_asserts: wire checks on the configuration link.
   Assumes one mclk_in domain and the levels seen in uts_if. */
`timescale 1ns/100ps
module uts_asserts (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic sck,
   input wire logic si,
   input wire logic en_n,
   input wire logic so_drv,
   input wire logic so_oe
);
   logic sck_q_r;
   logic [7:0] age_r;
   logic [7:0] age_nxt;
   // =====
   // cycles since sck last moved, saturating so long idles stay legal
   always_comb
   begin
      age_nxt = (sck != sck_q_r) ? 8'h00 : age_r + {7'h00, age_r != 8'hFF};
   end
   always_ff @(posedge mclk_in)
   begin
      sck_q_r <= sck;
      age_r <= rst_n_in ? age_nxt : 8'hFF;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // read data well past the launch latency
   sequence s_settled;
      so_oe && age_r > 8'h06;
   endsequence
   a_idle_high: assert property (en_n |-> sck && si)
      else $error("link not idle high");
   a_si_hold: assert property (!sck && !$past(sck) |-> $stable(si))
      else $error("si moved while sck low");
   a_en_move: assert property ($changed(en_n) |-> sck)
      else $error("en_n moved while sck low");
   a_sck_half: assert property ($changed(sck) |-> age_r >= 8'h62)
      else $error("sck half period short");
   a_so_frame: assert property (so_oe |-> !en_n)
      else $error("so driven outside frame");
   a_so_launch: assert property (so_oe && $past(so_oe) && $changed(so_drv)
      |-> sck && age_r < 8'h07)
      else $error("so changed away from sck rise");
   a_so_steady: assert property (s_settled |-> $stable(so_drv))
      else $error("so not steady");
   a_so_start: assert property ($rose(so_oe) |-> !sck ##1 !sck)
      else $error("so enabled off a fall");
   a_so_end: assert property ($fell(so_oe) |-> !sck)
      else $error("so released off a fall");
endmodule

// file: uts_dev.sv
/*
 * uts_dev: transmitter end of the three-wire configuration port, with
 * the register bank and the amplifier, regulator and PLL gating.
 * Assumes the link pins, the lock flag and the burst flag all come from
 * outside mclk_in; each passes a two-flop synchroniser first.
 */
// Contract
// - attenuation field sets amplifier power, eight steps
// - amplifier only on in transmit mode
// - gated mode: amplifier on at lock rise
// - open loop: amplifier off before PLL relocks; code does so only in gated mode, else it stays on
// - host floats transmit data after each burst
// - regulators off when disabled or sleeping
// - serial output driven only during read data
// - input bits shift on falling clock edges
// - read bits launched on rising clock edges
// - host never reads back in transmit mode
// - frame enable low for whole sequence
// - staged writes commit on enable rising edge
// - write frame: start, zero, address, data
// - read frame: start, one, address, data out
// - input high one clock between sequences
// - serial clock at most 1 MHz, balanced
// - idle clock and input held high
// - registers load defaults at power-up
// - host writes zero to undefined bits
// - mode field decodes sleep, standby, synth, transmit
// - lock output low unless indicator enabled
`timescale 1ns/100ps
module uts_dev (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   uts_if.dev link,
   input wire logic pll_locked_in,
   input wire logic tx_burst_in,
   output logic [1:0] op_mode_out,
   output logic [2:0] amp_atten_out,
   output logic amp_en_out,
   output logic regulator_on_out,
   output logic xosc_en_out,
   output logic pll_enable_out,
   output logic lock_indicator_out
);
   logic [uts_pkg::SY_LANES-1:0] raw;
   logic [uts_pkg::SY_LANES-1:0] syn;
   logic [uts_pkg::SY_LANES-1:0] syn_d_r;
   logic [uts_pkg::SY_LANES-1:0] syn_d_nxt;
   logic sck_fall;
   logic sck_rise;
   logic en_rise;
   logic si_s;

   uts_pkg::uts_dev_state_t st_r;
   uts_pkg::uts_dev_state_t st_nxt;
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic [7:0] sh_r;
   logic [7:0] sh_nxt;
   logic [4:0] addr_r;
   logic [4:0] addr_nxt;
   logic rw_r;
   logic rw_nxt;
   logic so_r;
   logic so_nxt;
   logic [7:0] stage_r [uts_pkg::NUM_REGS];
   logic [7:0] stage_nxt [uts_pkg::NUM_REGS];
   logic [7:0] act_r [uts_pkg::NUM_REGS];
   logic [7:0] act_nxt [uts_pkg::NUM_REGS];

   logic amp_r;
   logic amp_nxt;
   logic pll_en_r;
   logic pll_en_nxt;
   logic lock_ind_r;
   logic lock_ind_nxt;
   logic [1:0] mode;
   logic [1:0] mode_nxt;
   logic [1:0] modn;
   logic gated;
   logic open_loop;
   logic burst_fall;
   logic lock_rise;

   // ==========================================================
   // synchronisers and edge finding
   assign raw = {tx_burst_in, pll_locked_in, link.en_n, link.si, link.sck};

   // lock and burst idle low, the link lines idle high
   localparam logic [uts_pkg::SY_LANES-1:0] SYNC_IDLE =
      {{(uts_pkg::SY_LANES - uts_pkg::SY_LOCK){1'b0}}, {uts_pkg::SY_LOCK{1'b1}}};

   genvar g;
   generate
      for (g = 0; g < uts_pkg::SY_LANES; g++)
      begin : g_sync
         uts_sync #(.RESET_LEVEL(SYNC_IDLE[g])) u_sync (
            .mclk_in(mclk_in),
            .rst_n_in(rst_n_in),
            .d_in(raw[g]),
            .q_out(syn[g])
         );
      end
   endgenerate

   // one-cycle-old copies give the edges
   always_comb
   begin
      syn_d_nxt = syn;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         syn_d_r <= SYNC_IDLE;
      else
         syn_d_r <= syn_d_nxt;
   end

   assign sck_fall = syn_d_r[uts_pkg::SY_SCK] & ~syn[uts_pkg::SY_SCK];
   assign sck_rise = ~syn_d_r[uts_pkg::SY_SCK] & syn[uts_pkg::SY_SCK];
   assign en_rise = ~syn_d_r[uts_pkg::SY_EN] & syn[uts_pkg::SY_EN];
   assign si_s = syn[uts_pkg::SY_SI];

   // ==========================================================
   // serial frame engine and register bank
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      addr_nxt = addr_r;
      rw_nxt = rw_r;
      so_nxt = so_r;
      stage_nxt = stage_r;
      act_nxt = act_r;
      if (en_rise)
         act_nxt = stage_r;
      if (syn[uts_pkg::SY_EN])
         st_nxt = uts_pkg::UTS_D_IDLE;
      else if (sck_fall)
      begin
         case (st_r)
            uts_pkg::UTS_D_IDLE:
               if (si_s)
                  st_nxt = uts_pkg::UTS_D_READY;
            uts_pkg::UTS_D_READY:
               if (!si_s)
                  st_nxt = uts_pkg::UTS_D_RW;
            uts_pkg::UTS_D_RW:
            begin
               rw_nxt = si_s;
               cnt_nxt = '0;
               st_nxt = uts_pkg::UTS_D_ADDR;
            end
            uts_pkg::UTS_D_ADDR:
            begin
               addr_nxt = {addr_r[3:0], si_s};
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == uts_pkg::ADDR_LAST)
               begin
                  cnt_nxt = '0;
                  if (rw_r)
                  begin
                     st_nxt = uts_pkg::UTS_D_RDATA;
                     if (addr_nxt < uts_pkg::NUM_REGS_A)
                        sh_nxt = act_r[addr_nxt];
                     else
                        sh_nxt = uts_pkg::UNMAPPED_READ;
                  end
                  else
                     st_nxt = uts_pkg::UTS_D_WDATA;
               end
            end
            uts_pkg::UTS_D_WDATA:
            begin
               sh_nxt = {sh_r[6:0], si_s};
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == uts_pkg::DATA_LAST)
               begin
                  // staging only, the device keeps running on act_r
                  if (addr_r < uts_pkg::NUM_REGS_A)
                     stage_nxt[addr_r] = sh_nxt;
                  st_nxt = uts_pkg::UTS_D_IDLE;
               end
            end
            uts_pkg::UTS_D_RDATA:
            begin
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == uts_pkg::DATA_LAST)
                  st_nxt = uts_pkg::UTS_D_IDLE;
            end
            default:
               st_nxt = uts_pkg::UTS_D_IDLE;
         endcase
      end
      else if (sck_rise && st_r == uts_pkg::UTS_D_RDATA)
      begin
         so_nxt = sh_r[7];
         sh_nxt = {sh_r[6:0], 1'b0};
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= uts_pkg::UTS_D_IDLE;
         cnt_r <= '0;
         sh_r <= '0;
         addr_r <= '0;
         rw_r <= 1'b0;
         so_r <= 1'b0;
         for (int i = 0; i < uts_pkg::NUM_REGS; i++)
         begin
            stage_r[i] <= uts_pkg::REG_DEFAULTS[i*8 +: 8];
            act_r[i] <= uts_pkg::REG_DEFAULTS[i*8 +: 8];
         end
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         addr_r <= addr_nxt;
         rw_r <= rw_nxt;
         so_r <= so_nxt;
         stage_r <= stage_nxt;
         act_r <= act_nxt;
      end
   end

   assign link.so_drv = so_r;
   assign link.so_oe = (st_r == uts_pkg::UTS_D_RDATA);

   // ==========================================================
   // amplifier, lock flag and PLL gating
   assign mode = act_r[uts_pkg::REG_OP_MODE_POWER_CTRL]
      [uts_pkg::MODE_HI_BIT:uts_pkg::MODE_LO_BIT];
   assign modn = act_r[uts_pkg::REG_MODULATION_BAND_CTRL]
      [uts_pkg::MODN_MSB:uts_pkg::MODN_LSB];
   // amplifier judges the mode and gating that land with it (open loop from act_r): a commit turning
   // gating on is itself the mode event that clears it
   assign mode_nxt = act_nxt[uts_pkg::REG_OP_MODE_POWER_CTRL]
      [uts_pkg::MODE_HI_BIT:uts_pkg::MODE_LO_BIT];
   assign gated = act_nxt[uts_pkg::REG_MODULATION_BAND_CTRL]
      [uts_pkg::LOCK_GATED_AMP_EN_BIT]
      & act_nxt[uts_pkg::REG_MODULATION_BAND_CTRL][uts_pkg::LOCK_INDICATOR_EN_BIT];
   assign open_loop = (modn == uts_pkg::MODN_OPEN_LOOP);
   assign burst_fall = syn_d_r[uts_pkg::SY_BURST] & ~syn[uts_pkg::SY_BURST];
   assign lock_rise = lock_ind_nxt & ~lock_ind_r;

   // a lock already high on entry counts only if the same commit sets the indicator enable; otherwise only a fresh rise
   always_comb
   begin
      lock_ind_nxt = syn[uts_pkg::SY_LOCK]
         & act_r[uts_pkg::REG_MODULATION_BAND_CTRL]
         [uts_pkg::LOCK_INDICATOR_EN_BIT];
      amp_nxt = amp_r;
      if (mode_nxt != uts_pkg::MODE_TX)
         amp_nxt = 1'b0;
      else if (!gated)
         amp_nxt = 1'b1;
      else if (en_rise)
         amp_nxt = 1'b0;
      else if (open_loop && burst_fall)
         amp_nxt = 1'b0;
      else if (lock_rise)
         amp_nxt = 1'b1;
      // PLL held off one extra cycle so the amplifier is off first
      pll_en_nxt = mode[1] & ~(open_loop & (syn[uts_pkg::SY_BURST]
         | syn_d_r[uts_pkg::SY_BURST]));
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         amp_r <= 1'b0;
         pll_en_r <= 1'b0;
         lock_ind_r <= 1'b0;
      end
      else
      begin
         amp_r <= amp_nxt;
         pll_en_r <= pll_en_nxt;
         lock_ind_r <= lock_ind_nxt;
      end
   end

   assign op_mode_out = mode;
   assign amp_atten_out = act_r[uts_pkg::REG_OP_MODE_POWER_CTRL]
      [uts_pkg::ATT_MSB:uts_pkg::ATT_LSB];
   assign amp_en_out = amp_r;
   assign regulator_on_out = act_r[uts_pkg::REG_MODULATION_BAND_CTRL]
      [uts_pkg::REGULATOR_EN_BIT] & (mode != uts_pkg::MODE_SLEEP);
   assign xosc_en_out = (mode != uts_pkg::MODE_SLEEP);
   assign pll_enable_out = pll_en_r;
   assign lock_indicator_out = lock_ind_r;
endmodule

// file: uts_host.sv
/*
 * uts_host: host-side controller of the three-wire configuration link.
 * Assumes software on a plain register port; makes the serial clock
 * itself by dividing mclk_in, one frame per command.
 */
`timescale 1ns/100ps
module uts_host (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   uts_if.host link,
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out
);
   uts_pkg::uts_host_state_t st_r;
   uts_pkg::uts_host_state_t st_nxt;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [3:0] bit_r;
   logic [3:0] bit_nxt;
   logic [15:0] fr_r;
   logic [15:0] fr_nxt;
   logic rw_r;
   logic rw_nxt;
   logic sck_r;
   logic sck_nxt;
   logic en_n_r;
   logic en_n_nxt;
   logic [7:0] wdat_r;
   logic [7:0] wdat_nxt;
   logic [7:0] rdat_r;
   logic [7:0] rdat_nxt;
   logic [1:0] txc_r;
   logic [1:0] txc_nxt;
   logic tx_mode_r;
   logic tx_mode_nxt;
   logic refused_r;
   logic refused_nxt;
   logic [7:0] rout_r;
   logic [7:0] rout_nxt;
   logic so_s;
   logic busy;
   logic cmd_wr;

   uts_sync u_so_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .d_in(link.so_line),
      .q_out(so_s)
   );

   assign busy = (st_r != uts_pkg::UTS_H_IDLE);
   assign cmd_wr = wr_in && addr_in == uts_pkg::HREG_CMD && !busy;

   // ==========================================================
   // software registers and frame sequencer
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 8'h01;
      bit_nxt = bit_r;
      fr_nxt = fr_r;
      rw_nxt = rw_r;
      sck_nxt = sck_r;
      en_n_nxt = en_n_r;
      wdat_nxt = wdat_r;
      rdat_nxt = rdat_r;
      txc_nxt = txc_r;
      tx_mode_nxt = tx_mode_r;
      refused_nxt = refused_r;
      rout_nxt = 8'h00;
      if (wr_in && addr_in == uts_pkg::HREG_WDATA)
         wdat_nxt = wdata_in;
      if (wr_in && addr_in == uts_pkg::HREG_TXCTRL)
         txc_nxt = wdata_in[1:0];
      if (rd_in)
      begin
         if (addr_in == uts_pkg::HREG_STAT)
            rout_nxt = {6'h00, refused_r, busy};
         else if (addr_in == uts_pkg::HREG_RDATA)
            rout_nxt = rdat_r;
         else if (addr_in == uts_pkg::HREG_WDATA)
            rout_nxt = wdat_r;
         else if (addr_in == uts_pkg::HREG_TXCTRL)
            rout_nxt = {6'h00, txc_r};
      end
      case (st_r)
         uts_pkg::UTS_H_IDLE:
         begin
            sck_nxt = 1'b1;
            en_n_nxt = 1'b1;
            cnt_nxt = '0;
            if (cmd_wr && wdata_in[uts_pkg::CMD_RW_BIT] && tx_mode_r)
               refused_nxt = 1'b1;
            else if (cmd_wr)
            begin
               refused_nxt = 1'b0;
               rw_nxt = wdata_in[uts_pkg::CMD_RW_BIT];
               // guard high, start low, direction, address, data
               fr_nxt = {uts_pkg::FRAME_GUARD, uts_pkg::FRAME_START,
                  wdata_in[uts_pkg::CMD_RW_BIT], wdata_in[4:0],
                  wdata_in[uts_pkg::CMD_RW_BIT] ? uts_pkg::READ_FILL
                  : wdat_r};
               if (!wdata_in[uts_pkg::CMD_RW_BIT]
                  && wdata_in[4:0] == uts_pkg::REG_OP_MODE_POWER_CTRL)
                  tx_mode_nxt = (wdat_r[uts_pkg::MODE_HI_BIT:uts_pkg::MODE_LO_BIT]
                     == uts_pkg::MODE_TX);
               bit_nxt = '0;
               en_n_nxt = 1'b0;
               st_nxt = uts_pkg::UTS_H_HIGH;
            end
         end
         uts_pkg::UTS_H_HIGH:
            if (cnt_r == uts_pkg::SCK_HALF_CYC - 8'h01)
            begin
               cnt_nxt = '0;
               sck_nxt = 1'b0;
               if (rw_r && bit_r > 4'h7)
                  rdat_nxt = {rdat_r[6:0], so_s};
               st_nxt = uts_pkg::UTS_H_LOW;
            end
         uts_pkg::UTS_H_LOW:
            if (cnt_r == uts_pkg::SCK_HALF_CYC - 8'h01)
            begin
               cnt_nxt = '0;
               sck_nxt = 1'b1;
               fr_nxt = {fr_r[14:0], 1'b1};
               bit_nxt = bit_r + 4'h1;
               if (bit_r == uts_pkg::FRAME_LAST)
                  st_nxt = uts_pkg::UTS_H_FIN;
               else
                  st_nxt = uts_pkg::UTS_H_HIGH;
            end
         uts_pkg::UTS_H_FIN:
            if (cnt_r == uts_pkg::SCK_HALF_CYC - 8'h01)
            begin
               cnt_nxt = '0;
               en_n_nxt = 1'b1;
               st_nxt = uts_pkg::UTS_H_GAP;
            end
         uts_pkg::UTS_H_GAP:
            // enable high long enough for the device to see it
            if (cnt_r == uts_pkg::SCK_HALF_CYC - 8'h01)
               st_nxt = uts_pkg::UTS_H_IDLE;
         default:
            st_nxt = uts_pkg::UTS_H_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= uts_pkg::UTS_H_IDLE;
         cnt_r <= '0;
         bit_r <= '0;
         fr_r <= 16'hFFFF;
         rw_r <= 1'b0;
         sck_r <= 1'b1;
         en_n_r <= 1'b1;
         wdat_r <= '0;
         rdat_r <= '0;
         txc_r <= '0;
         tx_mode_r <= 1'b0;
         refused_r <= 1'b0;
         rout_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         fr_r <= fr_nxt;
         rw_r <= rw_nxt;
         sck_r <= sck_nxt;
         en_n_r <= en_n_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
         txc_r <= txc_nxt;
         tx_mode_r <= tx_mode_nxt;
         refused_r <= refused_nxt;
         rout_r <= rout_nxt;
      end
   end

   assign link.sck = sck_r;
   assign link.si = fr_r[15] | en_n_r;
   assign link.en_n = en_n_r;
   assign link.tx_drv = txc_r[uts_pkg::TX_VAL_BIT];
   assign link.tx_oe = txc_r[uts_pkg::TX_DRV_BIT];
   assign rdata_out = rout_r;
endmodule

// file: uts_if.sv
/*
 * uts_if: the three-wire configuration link plus the transmit data pin.
 * Assumes a pull-up on both tri-stated lines; the level is resolved here.
 */
`timescale 1ns/100ps
interface uts_if;
   logic sck;
   logic si;
   logic en_n;
   logic so_drv;
   logic so_oe;
   logic so_line;
   logic tx_drv;
   logic tx_oe;
   logic tx_line;

   // ==========================================================
   // wire resolution, released lines float high
   assign so_line = so_oe ? so_drv : 1'b1;
   assign tx_line = tx_oe ? tx_drv : 1'b1;

   modport dev (input sck, input si, input en_n, input tx_line,
      output so_drv, output so_oe);
   modport host (output sck, output si, output en_n, output tx_drv,
      output tx_oe, input so_line);
endinterface

// file: uts_pkg.sv
/*
 * uts_pkg: shared constants and types for the three-wire configuration
 * port of the transmitter and for the host-side controller.
 * Assumes both ends run on a 200 MHz mclk_in.
 */
package uts_pkg;

   // ==========================================================
   // register bank
   localparam int NUM_REGS = 18;
   localparam logic [4:0] NUM_REGS_A = 5'h12;
   localparam logic [4:0] REG_OP_MODE_POWER_CTRL = 5'h00;
   localparam logic [4:0] REG_MODULATION_BAND_CTRL = 5'h01;
   localparam logic [4:0] REG_OSC_AMP_STARTUP_CTRL = 5'h02;
   localparam logic [4:0] REG_DEVIATION_CTRL = 5'h03;
   localparam logic [4:0] REG_BITRATE_FILTER_CTRL = 5'h04;
   localparam logic [4:0] REG_REFERENCE_DIVIDER = 5'h05;
   localparam logic [4:0] REG_SWALLOW_COUNT_SET0 = 5'h06;
   localparam logic [4:0] REG_DIVN_SET0_HIGH = 5'h07;
   localparam logic [4:0] REG_DIVN_SET0_LOW = 5'h08;
   localparam logic [4:0] REG_DIVM_SET0_HIGH = 5'h09;
   localparam logic [4:0] REG_DIVM_SET0_LOW = 5'h0A;
   localparam logic [4:0] REG_SWALLOW_COUNT_SET1 = 5'h0B;
   localparam logic [4:0] REG_DIVN_SET1_HIGH = 5'h0C;
   localparam logic [4:0] REG_DIVN_SET1_LOW = 5'h0D;
   localparam logic [4:0] REG_DIVM_SET1_HIGH = 5'h0E;
   localparam logic [4:0] REG_DIVM_SET1_LOW = 5'h0F;
   localparam logic [4:0] REG_OSCILLATOR_BIAS_PRESCALE = 5'h10;
   localparam logic [4:0] REG_AMP_BIAS_CURRENT = 5'h11;
   // power-up values, register 0 in the low byte
   localparam logic [8*NUM_REGS-1:0] REG_DEFAULTS = {
      8'hDD, 8'h20, 8'h22, 8'h00, 8'h76, 8'h00, 8'h02, 8'h22, 8'h00,
      8'h76, 8'h00, 8'h02, 8'h1A, 8'h0C, 8'h4B, 8'h02, 8'h7D, 8'h3F};
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ==========================================================
   // field positions and codes
   localparam int MODE_HI_BIT = 6;
   localparam int MODE_LO_BIT = 5;
   localparam int ATT_MSB = 4;
   localparam int ATT_LSB = 2;
   localparam int MODN_MSB = 7;
   localparam int MODN_LSB = 6;
   localparam int REGULATOR_EN_BIT = 3;
   localparam int LOCK_GATED_AMP_EN_BIT = 1;
   localparam int LOCK_INDICATOR_EN_BIT = 0;
   localparam logic [1:0] MODE_SLEEP = 2'h0;
   localparam logic [1:0] MODE_TX = 2'h3;
   localparam logic [1:0] MODN_OPEN_LOOP = 2'h1;

   // ==========================================================
   // serial frame
   localparam logic [2:0] ADDR_LAST = 3'h4;
   localparam logic [2:0] DATA_LAST = 3'h7;
   localparam logic [3:0] FRAME_LAST = 4'hF;
   localparam logic FRAME_GUARD = 1'b1;
   localparam logic FRAME_START = 1'b0;
   localparam logic [7:0] READ_FILL = 8'hFF;
   // synchroniser lanes in the device
   localparam int SY_SCK = 0;
   localparam int SY_SI = 1;
   localparam int SY_EN = 2;
   localparam int SY_LOCK = 3;
   localparam int SY_BURST = 4;
   localparam int SY_LANES = 5;

   // ==========================================================
   // host timing and host registers
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCK_HALF_NS = 500;
   localparam logic [7:0] SCK_HALF_CYC =
      8'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] HREG_CMD = 3'h0;
   localparam logic [2:0] HREG_WDATA = 3'h1;
   localparam logic [2:0] HREG_STAT = 3'h2;
   localparam logic [2:0] HREG_RDATA = 3'h3;
   localparam logic [2:0] HREG_TXCTRL = 3'h4;
   localparam int CMD_RW_BIT = 7;
   localparam int TX_VAL_BIT = 0;
   localparam int TX_DRV_BIT = 1;

   // ==========================================================
   // state types
   typedef enum logic [5:0] {
      UTS_D_IDLE = 6'h01,
      UTS_D_READY = 6'h02,
      UTS_D_RW = 6'h04,
      UTS_D_ADDR = 6'h08,
      UTS_D_WDATA = 6'h10,
      UTS_D_RDATA = 6'h20
   } uts_dev_state_t;

   typedef enum logic [4:0] {
      UTS_H_IDLE = 5'h01,
      UTS_H_HIGH = 5'h02,
      UTS_H_LOW = 5'h04,
      UTS_H_FIN = 5'h08,
      UTS_H_GAP = 5'h10
   } uts_host_state_t;

endpackage

// file: uts_sync.sv
/*
 * uts_sync: two-flop synchroniser for one level from another domain.
 * Assumes the input changes far slower than mclk_in.
 */
`timescale 1ns/100ps
module uts_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta_r;
   logic meta_nxt;
   logic q_r;
   logic q_nxt;

   // ==========================================================
   // first stage feeds only the second
   always_comb
   begin
      meta_nxt = d_in;
      q_nxt = meta_r;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         // idle level of the pin, so no false edge follows reset
         meta_r <= RESET_LEVEL;
         q_r <= RESET_LEVEL;
      end
      else
      begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
      end
   end

   assign q_out = q_r;
endmodule
